// ===== core/npr_pkg.sv
// constants shared by the nonce, pause and random command block
package npr_pkg;

    // ------------------------------------------------------------
    // command opcodes and mode fields
    // ------------------------------------------------------------
    localparam logic [7:0]  OPC_PAUSE       = 8'h01;
    localparam logic [7:0]  OPC_NONCE       = 8'h16;
    localparam logic [7:0]  OPC_RANDOM      = 8'h1B;
    localparam logic [1:0]  MODE_INVALID    = 2'h2;
    localparam logic [1:0]  MODE_PASS       = 2'h3;

    // ------------------------------------------------------------
    // lengths and answer codes
    // ------------------------------------------------------------
    localparam logic [5:0]  LEN_NONCE_HASH  = 6'h14;
    localparam logic [5:0]  LEN_NONCE_PASS  = 6'h20;
    localparam logic [5:0]  LEN_RANDOM_OUT  = 6'h20;
    localparam logic [5:0]  LEN_ONE_BYTE    = 6'h01;
    localparam logic [3:0]  RAND_WORDS      = 4'h8;
    localparam logic [7:0]  CODE_OK         = 8'h00;
    localparam logic [7:0]  CODE_PARAM      = 8'h03;
    localparam logic [7:0]  CODE_EXEC       = 8'h0F;

    // ------------------------------------------------------------
    // random source values after reset and while unlocked, refresh length and endurance defaults
    // ------------------------------------------------------------
    localparam logic [31:0] TEST_WORD       = 32'h0000FFFF;
    localparam logic [31:0] SEED_RESET      = 32'h00000001;
    localparam int          REFRESH_CYC_DEF = 16;
    localparam int          ENDURANCE_DEF   = 1000;

    // ------------------------------------------------------------
    // register offsets and field positions
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL       = 4'h0;
    localparam logic [3:0]  ADDR_STATUS     = 4'h1;
    localparam logic [3:0]  ADDR_DIGEST0    = 4'h2;
    localparam logic [3:0]  ADDR_DIGEST7    = 4'h9;
    localparam int          CTRL_LOCK_BIT   = 0;
    localparam int          CTRL_WAKE_BIT   = 1;
    localparam int          CTRL_SEL_LSB    = 8;
    localparam int          ST_VALID_BIT    = 0;
    localparam int          ST_ORIGIN_BIT   = 1;
    localparam int          ST_IDLE_BIT     = 2;
    localparam int          ST_STALE_BIT    = 3;
    localparam int          ST_USABLE_BIT   = 4;
    localparam int          ST_ENDUR_LSB    = 16;

    typedef enum logic [2:0] {
        ST_READY,
        ST_REFRESH,
        ST_GEN,
        ST_HASH,
        ST_SEND,
        ST_IDLE
    } npr_state_t;

endpackage

// ===== core/npr_command_core.sv
// nonce, pause and random command execution with its register port
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module npr_command_core
    import npr_pkg::*;
#(
    parameter int REFRESH_CYCLES  = REFRESH_CYC_DEF,
    parameter int ENDURANCE_LIMIT = ENDURANCE_DEF
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // command from the serial front end
    input  wire logic         cmdValid,
    output logic              cmdReady,
    input  wire logic [7:0]   cmdOpcode,
    input  wire logic [7:0]   firstParameter,
    input  wire logic [15:0]  secondParameter,
    input  wire logic [5:0]   hostInputLen,
    input  wire logic [255:0] hostInputValue,
    // response byte stream
    output logic              respValidQ,
    output logic [7:0]        respByteQ,
    output logic              respLastQ,
    // hardware generator and hash engine
    input  wire logic [31:0]  trngWord,
    output logic              shaStartQ,
    output logic [439:0]      shaMessageQ,
    input  wire logic         shaDone,
    input  wire logic [255:0] shaDigest,
    // digest state seen by later commands, and the idle flag
    output logic              digestValidQ,
    output logic              digestOriginFlagQ,
    output logic              digestKeyUsable,
    output logic              deviceIdle,
    // register port
    input  wire logic [3:0]   regAddr,
    input  wire logic [31:0]  regWdata,
    input  wire logic         regWrite,
    input  wire logic         regRead,
    output logic [31:0]       regRdataQ
);

    // ------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------
    npr_state_t        stateQ;
    logic [7:0]        opcodeQ;
    logic [7:0]        modeQ;
    logic [7:0]        codeQ;
    logic              sendRandQ;
    logic [5:0]        sendLenQ;
    logic [5:0]        sendIdxQ;
    logic [3:0]        genIdxQ;
    logic [15:0]       refreshCntQ;
    logic [31:0]       seedQ;
    logic              seedStaleQ;
    logic [15:0]       enduranceQ;
    logic [31:0]       randBuf [0:7];
    logic [255:0]      digestQ;
    logic [159:0]      nonceInputQ;
    logic [15:0]       secondParamQ;
    logic              configLockedQ;
    logic [7:0]        selectorQ;
    logic              wakeQ;

    // ------------------------------------------------------------
    // command checks
    // ------------------------------------------------------------
    logic accept;
    logic nonceBad;
    logic randomBad;
    logic pauseBad;
    logic needRefresh;
    logic exhausted;
    logic [31:0] genWord;
    logic [31:0] sendWord;

    // seed stepping shared by refresh and generation
    function automatic logic [31:0] seedMix(input logic [31:0] s, input logic [31:0] t);
        seedMix = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]} ^ t;
    endfunction

    assign cmdReady        = (stateQ == ST_READY);
    assign accept          = cmdValid && cmdReady;
    assign deviceIdle      = (stateQ == ST_IDLE);
    // a pass-through digest cannot serve as a key source
    assign digestKeyUsable = digestValidQ && digestOriginFlagQ;

    // parameter checks per opcode
    assign nonceBad  = (firstParameter[7:2] != 6'h00) || (firstParameter[1:0] == MODE_INVALID)
                     || (secondParameter != 16'h0000)
                     || (hostInputLen != ((firstParameter[1:0] == MODE_PASS) ? LEN_NONCE_PASS
                                                                            : LEN_NONCE_HASH));
    assign randomBad = (firstParameter[7:1] != 7'h00) || (secondParameter != 16'h0000)
                     || (hostInputLen != 6'h00);
    assign pauseBad  = (secondParameter != 16'h0000) || (hostInputLen != 6'h00);

    // mode bit zero clear asks for a refresh when the seed is stale
    assign needRefresh = !firstParameter[0] && seedStaleQ;
    assign exhausted   = (enduranceQ >= 16'(ENDURANCE_LIMIT));

    // generator word: test pattern until configuration is locked
    assign genWord  = configLockedQ ? seedMix(seedQ, trngWord) : TEST_WORD;
    assign sendWord = randBuf[sendIdxQ[4:2]];

    // ------------------------------------------------------------
    // command sequencing
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stateQ      <= ST_READY;
            codeQ       <= CODE_OK;
            sendRandQ   <= 1'b0;
            sendLenQ    <= 6'h00;
            sendIdxQ    <= 6'h00;
            genIdxQ     <= 4'h0;
            refreshCntQ <= 16'h0000;
        end else begin
            unique case (stateQ)
                ST_READY: begin
                    sendIdxQ  <= 6'h00;
                    genIdxQ   <= 4'h0;
                    sendRandQ <= 1'b0;
                    sendLenQ  <= LEN_ONE_BYTE;
                    codeQ     <= CODE_OK;
                    refreshCntQ <= 16'(REFRESH_CYCLES - 1);
                    if (accept) begin
                        if (cmdOpcode == OPC_NONCE || cmdOpcode == OPC_RANDOM) begin
                            if ((cmdOpcode == OPC_NONCE) ? nonceBad : randomBad) begin
                                codeQ  <= CODE_PARAM;
                                stateQ <= ST_SEND;
                            end else if (cmdOpcode == OPC_NONCE && firstParameter[1:0] == MODE_PASS) begin
                                stateQ <= ST_SEND; // single zero byte
                            end else if (needRefresh && exhausted) begin
                                codeQ  <= CODE_EXEC;
                                stateQ <= ST_SEND;
                            end else if (needRefresh) begin
                                stateQ <= ST_REFRESH;
                            end else begin
                                stateQ <= ST_GEN;
                            end
                        end else if (cmdOpcode == OPC_PAUSE) begin
                            if (pauseBad) begin
                                codeQ  <= CODE_PARAM;
                                stateQ <= ST_SEND;
                            end else if (firstParameter != selectorQ) begin
                                stateQ <= ST_IDLE; // idle only, no answer
                            end else begin
                                stateQ <= ST_SEND; // answer zero
                            end
                        end else begin
                            codeQ  <= CODE_PARAM;
                            stateQ <= ST_SEND;
                        end
                    end
                end
                ST_REFRESH: begin
                    refreshCntQ <= refreshCntQ - 16'h0001;
                    if (refreshCntQ == 16'h0000) begin
                        stateQ <= ST_GEN;
                    end
                end
                ST_GEN: begin
                    genIdxQ <= genIdxQ + 4'h1;
                    if (genIdxQ == RAND_WORDS - 4'h1) begin
                        sendRandQ <= 1'b1;
                        sendLenQ  <= LEN_RANDOM_OUT;
                        stateQ    <= (opcodeQ == OPC_NONCE) ? ST_HASH : ST_SEND;
                    end
                end
                ST_HASH: begin
                    if (shaDone) begin
                        stateQ <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    sendIdxQ <= sendIdxQ + 6'h01;
                    if (sendIdxQ == sendLenQ - 6'h01) begin
                        stateQ <= ST_READY;
                    end
                end
                ST_IDLE: begin
                    if (wakeQ) begin
                        stateQ <= ST_READY;
                    end
                end
            endcase
        end
    end

    // latch of the accepted command fields
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            opcodeQ      <= 8'h00;
            modeQ        <= 8'h00;
            secondParamQ <= 16'h0000;
            nonceInputQ  <= '0;
        end else if (accept) begin
            opcodeQ      <= cmdOpcode;
            modeQ        <= firstParameter;
            secondParamQ <= secondParameter;
            nonceInputQ  <= hostInputValue[159:0];
        end
    end

    // ------------------------------------------------------------
    // seed, refresh endurance and random words
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seedQ      <= SEED_RESET;
            seedStaleQ <= 1'b1;
            enduranceQ <= 16'h0000;
        end else if (stateQ == ST_REFRESH && refreshCntQ == 16'h0000) begin
            seedQ      <= seedMix(seedQ, trngWord);
            seedStaleQ <= 1'b0;
            enduranceQ <= enduranceQ + 16'h0001;
        end else if (stateQ == ST_GEN) begin
            seedQ      <= seedMix(seedQ, trngWord);
            seedStaleQ <= 1'b1;
        end
    end

    // random buffer, one word per generation cycle
    always_ff @(posedge ref_clk) begin
        if (stateQ == ST_GEN) begin
            randBuf[genIdxQ[2:0]] <= genWord;
        end
    end

    // ------------------------------------------------------------
    // hash request and digest register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shaStartQ   <= 1'b0;
            shaMessageQ <= '0;
        end else begin
            shaStartQ <= (stateQ == ST_GEN) && (genIdxQ == RAND_WORDS - 4'h1) && (opcodeQ == OPC_NONCE);
            if (stateQ == ST_GEN && genIdxQ == RAND_WORDS - 4'h1) begin
                shaMessageQ <= {randBuf[0], randBuf[1], randBuf[2], randBuf[3], randBuf[4], randBuf[5],
                                randBuf[6], genWord, nonceInputQ, OPC_NONCE, modeQ, secondParamQ[7:0]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            digestQ           <= '0;
            digestValidQ      <= 1'b0;
            digestOriginFlagQ <= 1'b0;
        end else if (accept && cmdOpcode == OPC_NONCE && !nonceBad && firstParameter[1:0] == MODE_PASS) begin
            digestQ           <= hostInputValue;
            digestValidQ      <= 1'b1;
            digestOriginFlagQ <= 1'b0;
        end else if (stateQ == ST_HASH && shaDone) begin
            digestQ           <= shaDigest;
            digestValidQ      <= 1'b1;
            digestOriginFlagQ <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // response byte stream
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            respValidQ <= 1'b0;
            respByteQ  <= 8'h00;
            respLastQ  <= 1'b0;
        end else begin
            respValidQ <= (stateQ == ST_SEND);
            respLastQ  <= (stateQ == ST_SEND) && (sendIdxQ == sendLenQ - 6'h01);
            respByteQ  <= (stateQ != ST_SEND) ? 8'h00 :
                          sendRandQ ? sendWord[{sendIdxQ[1:0], 3'b000} +: 8] : codeQ;
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            configLockedQ <= 1'b0;
            selectorQ     <= 8'h00;
            wakeQ         <= 1'b0;
        end else begin
            wakeQ <= regWrite && (regAddr == ADDR_CTRL) && regWdata[CTRL_WAKE_BIT];
            if (regWrite && regAddr == ADDR_CTRL) begin
                configLockedQ <= regWdata[CTRL_LOCK_BIT];
                selectorQ     <= regWdata[CTRL_SEL_LSB +: 8];
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst || !regRead) begin
            regRdataQ <= 32'h00000000;
        end else if (regAddr == ADDR_CTRL) begin
            regRdataQ <= {16'h0000, selectorQ, 7'h00, configLockedQ};
        end else if (regAddr == ADDR_STATUS) begin
            regRdataQ <= {enduranceQ, 11'h000, digestKeyUsable, seedStaleQ, deviceIdle,
                          digestOriginFlagQ, digestValidQ};
        end else if (regAddr >= ADDR_DIGEST0 && regAddr <= ADDR_DIGEST7) begin
            regRdataQ <= digestQ[{3'(regAddr - ADDR_DIGEST0), 5'h00} +: 32];
        end else begin
            regRdataQ <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // cycles spent in the current seed refresh, counted apart from the sequencer
    logic [15:0] refreshRunQ;

    always_ff @(posedge ref_clk) begin
        if (rst || stateQ != ST_REFRESH) begin
            refreshRunQ <= 16'h0000;
        end else begin
            refreshRunQ <= refreshRunQ + 16'h0001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence genRun;
        (stateQ == ST_GEN) [*8];
    endsequence

    sequence oneByteAnswer(logic [7:0] code);
        respValidQ && respLastQ && (respByteQ == code);
    endsequence

    a_pass_one_byte:
        assert property (accept && cmdOpcode == OPC_NONCE && !nonceBad && firstParameter[1:0] == MODE_PASS
                         |-> ##2 oneByteAnswer(CODE_OK))
        else $error("pass-through nonce did not answer one zero byte");

    a_random_words:
        assert property (accept && cmdOpcode == OPC_RANDOM && !randomBad && !needRefresh
                         |=> genRun ##1 (stateQ == ST_SEND && sendLenQ == LEN_RANDOM_OUT))
        else $error("random command did not generate 32 bytes");

    a_origin_rand:
        assert property (stateQ == ST_HASH && shaDone |=> digestOriginFlagQ && digestValidQ && digestKeyUsable)
        else $error("hashed nonce did not mark digest as random");

    a_origin_input:
        assert property (accept && cmdOpcode == OPC_NONCE && !nonceBad && firstParameter[1:0] == MODE_PASS
                         |=> !digestOriginFlagQ && digestValidQ && !digestKeyUsable
                             && digestQ == $past(hostInputValue))
        else $error("pass-through digest not loaded as input origin");

    a_no_refresh_m1:
        assert property (accept && firstParameter[0] && (cmdOpcode == OPC_NONCE || cmdOpcode == OPC_RANDOM)
                         && !((cmdOpcode == OPC_NONCE) ? nonceBad : randomBad)
                         |=> stateQ != ST_REFRESH)
        else $error("mode one refreshed the seed");

    a_refresh_m0:
        assert property (accept && cmdOpcode == OPC_RANDOM && !randomBad && needRefresh && !exhausted
                         |=> stateQ == ST_REFRESH)
        else $error("stale seed not refreshed before generation");

    a_refresh_end:
        assert property (stateQ == ST_REFRESH && refreshRunQ == 16'(REFRESH_CYCLES - 1)
                         |=> stateQ == ST_GEN && !seedStaleQ)
        else $error("seed refresh did not end fresh after its length");

    a_pause_idle:
        assert property (accept && cmdOpcode == OPC_PAUSE && !pauseBad && firstParameter != selectorQ
                         |=> deviceIdle ##1 !respValidQ)
        else $error("pause mismatch did not idle silently");

    a_pause_match:
        assert property (accept && cmdOpcode == OPC_PAUSE && !pauseBad && firstParameter == selectorQ
                         |-> ##2 oneByteAnswer(CODE_OK))
        else $error("pause match did not answer zero");

    a_endurance_err:
        assert property (accept && cmdOpcode == OPC_RANDOM && !randomBad && needRefresh && exhausted
                         |-> ##2 oneByteAnswer(CODE_EXEC))
        else $error("exhausted refresh did not answer error");

    a_nonce_param:
        assert property (accept && cmdOpcode == OPC_NONCE && nonceBad |-> ##2 oneByteAnswer(CODE_PARAM))
        else $error("bad nonce parameters not refused");

    a_test_pattern:
        assert property (stateQ == ST_SEND && sendRandQ && !$past(configLockedQ, 40) && !configLockedQ
                         && $stable(configLockedQ) |=> respByteQ == ($past(sendIdxQ[1]) ? 8'h00 : 8'hFF))
        else $error("unlocked generator did not give test pattern");

endmodule

// ===== dv/npr_hash_model.sv
// hash engine stand-in that answers a start pulse after a chosen lag
`timescale 1ns/1ps
module npr_hash_model (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // request and chosen lag
    input  wire logic         start,
    input  wire logic [439:0] msg,
    input  wire logic [3:0]   lag,
    // answer
    output logic              done,
    output logic [255:0]      dig
);
    logic         busy_q;
    logic [3:0]   cnt_q;
    logic [255:0] dig_q;
    // digest is the inverted random words; outside done the bus shows its inverse
    assign done = busy_q && (cnt_q == 4'h0);
    assign dig  = done ? dig_q : ~dig_q;
    // count the lag down after each start
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            cnt_q  <= 4'h0;
            dig_q  <= 256'h0;
        end else if (start) begin
            busy_q <= 1'b1;
            cnt_q  <= lag;
            dig_q  <= ~msg[439:184];
        end else if (busy_q) begin
            busy_q <= (cnt_q != 4'h0);
            cnt_q  <= cnt_q - 4'h1;
        end
    end
endmodule

// ===== dv/testbench.sv
// self-checking bench for the nonce, pause and random command core
`timescale 1ns/1ps
module testbench;
    import npr_pkg::*;
    // ----------------------------------------
    // signals and bookkeeping
    // ----------------------------------------
    logic         ref_clk = 0, rst = 1, cmdValid = 0, regWrite = 0, regRead = 0;
    logic [7:0]   cmdOpcode = 0, firstParameter = 0, respByteQ, rq[$];
    logic [15:0]  secondParameter = 0;
    logic [5:0]   hostInputLen = 0;
    logic [255:0] hostInputValue = 0, shaDigest;
    logic [31:0]  trngWord = 0, regWdata = 0, regRdataQ, rd;
    logic [3:0]   regAddr = 0, lag = 0;
    logic [439:0] shaMessageQ, msg;
    logic         cmdReady, respValidQ, respLastQ, shaStartQ, shaDone;
    logic         digestValidQ, digestOriginFlagQ, digestKeyUsable, deviceIdle;
    int           errors = 0, cmp_count = 0, seed = 32'h7AAA1206, i;
    logic [37:0]  et [7] = '{{OPC_NONCE, 8'h02, 16'h0, LEN_NONCE_HASH}, {OPC_NONCE, 8'h80, 16'h0, LEN_NONCE_HASH},
        {OPC_NONCE, 8'h00, 16'h0, LEN_NONCE_PASS}, {OPC_NONCE, 8'h03, 16'h0, LEN_NONCE_HASH},
        {OPC_RANDOM, 8'h00, 16'h0, LEN_NONCE_HASH}, {OPC_PAUSE, 8'h00, 16'h0001, 6'h00}, {8'h55, 24'h0, 6'h00}};
    // ----------------------------------------
    // design, hash partner, clock, generator
    // ----------------------------------------
    npr_command_core #(.REFRESH_CYCLES(2), .ENDURANCE_LIMIT(2)) DUT (.ref_clk, .rst, .cmdValid, .cmdReady,
        .cmdOpcode, .firstParameter, .secondParameter, .hostInputLen, .hostInputValue, .respValidQ, .respByteQ,
        .respLastQ, .trngWord, .shaStartQ, .shaMessageQ, .shaDone, .shaDigest, .digestValidQ,
        .digestOriginFlagQ, .digestKeyUsable, .deviceIdle, .regAddr, .regWdata, .regWrite, .regRead, .regRdataQ);
    npr_hash_model hm (.ref_clk, .rst, .start(shaStartQ), .msg(shaMessageQ), .lag, .done(shaDone), .dig(shaDigest));
    always #5 ref_clk = ~ref_clk;
    // fresh generator word every cycle, and capture of each hash request
    always @(posedge ref_clk) begin
        trngWord <= $random(seed);
        if (shaStartQ === 1'b1) msg = shaMessageQ;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input logic [31:0] g, e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task rdr(input logic [3:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(negedge ref_clk);
        rd = regRdataQ;
    endtask
    // offer one command, then gather its answer bytes
    task cmd(input logic [7:0] op, fp, input logic [15:0] sp, input logic [5:0] len);
        rq = {};
        @(posedge ref_clk);
        cmdOpcode <= op;
        firstParameter <= fp;
        secondParameter <= sp;
        hostInputLen <= len;
        cmdValid <= 1'b1;
        do @(negedge ref_clk); while (cmdReady !== 1'b1);
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        for (int n = 0; n < 120; n++) begin
            @(negedge ref_clk);
            if (respValidQ === 1'b1) rq.push_back(respByteQ);
            if (respLastQ === 1'b1) break;
        end
    endtask
    task one(input logic [7:0] c);
        chk(rq.size(), 1);
        chk(rq[0], c);
    endtask
    task rnd(input logic [3:0] l);
        @(posedge ref_clk);
        lag <= l;
        for (int k = 0; k < 8; k++) hostInputValue[32*k+:32] <= $random(seed);
    endtask
    task dg(input logic [255:0] e);
        for (int k = 0; k < 8; k++) begin
            rdr(4'(ADDR_DIGEST0 + k));
            chk(rd, e[32*k+:32]);
        end
    endtask
    // hashed nonce: answer bytes are the hashed random words, tail and digest follow
    task hn(input logic [7:0] m, input logic [3:0] l, input logic [15:0] cnt);
        rnd(l);
        cmd(OPC_NONCE, m, 16'h0, LEN_NONCE_HASH);
        chk(rq.size(), 32);
        for (int k = 0; k < 32; k++) chk(rq[k], msg[408-32*(k/4)+8*(k%4)+:8]);
        for (int k = 0; k < 5; k++) chk(msg[24+32*k+:32], hostInputValue[32*k+:32]);
        chk(msg[23:0], {OPC_NONCE, m, 8'h00});
        dg(~msg[439:184]);
        rdr(ADDR_STATUS);
        chk(rd, {cnt, 16'h001B});
        chk({digestValidQ, digestOriginFlagQ, digestKeyUsable}, 3'b111);
    endtask
    task stop_test;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rdr(ADDR_STATUS);
        chk(rd, 32'h0000_0008);
        rdr(4'hF);
        chk(rd, 32'h0);
        cmd(OPC_RANDOM, 8'h01, 16'h0, 6'h00);
        chk(rq.size(), 32);
        for (i = 0; i < 32; i++) chk(rq[i], (i % 4 < 2) ? 8'hFF : 8'h00);
        rnd(4'h0);
        cmd(OPC_NONCE, 8'h03, 16'h0, LEN_NONCE_PASS);
        one(CODE_OK);
        dg(hostInputValue);
        rdr(ADDR_STATUS);
        chk(rd, 32'h0000_0009);
        chk({digestValidQ, digestOriginFlagQ, digestKeyUsable}, 3'b100);
        for (i = 0; i < 7; i++) begin
            cmd(et[i][37:30], et[i][29:22], et[i][21:6], et[i][5:0]);
            one(CODE_PARAM);
        end
        wr(ADDR_CTRL, 32'h0000_5A00);
        cmd(OPC_PAUSE, 8'h5A, 16'h0, 6'h00);
        one(CODE_OK);
        chk(deviceIdle, 0);
        cmd(OPC_PAUSE, 8'h5B, 16'h0, 6'h00);
        chk(rq.size(), 0);
        chk({deviceIdle, cmdReady}, 2'b10);
        rdr(ADDR_STATUS);
        chk(rd[2], 1);
        wr(ADDR_CTRL, 32'h0000_5A03);
        rdr(ADDR_CTRL);
        chk(rd, 32'h0000_5A01);
        chk(deviceIdle, 0);
        hn(8'h01, 4'h0, 16'h0);
        hn(8'h00, 4'hC, 16'h1);
        cmd(OPC_RANDOM, 8'h00, 16'h0, 6'h00);
        rdr(ADDR_STATUS);
        chk({16'(rq.size()), rd[31:16]}, {16'd32, 16'h0002});
        cmd(OPC_RANDOM, 8'h00, 16'h0, 6'h00);
        one(CODE_EXEC);
        cmd(OPC_NONCE, 8'h00, 16'h0, LEN_NONCE_HASH);
        one(CODE_EXEC);
        hn(8'h01, 4'h3, 16'h2);
        stop_test();
    end
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule
